/* File: hw/txe_exec.sv */
// Executor for trap-immediate, external-enable writes and xor instructions
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module txe_exec
    import txe_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire txe_exec_req_s EXE_REQ,
    input wire logic XER_SO,
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    output txe_gpr_wr_s GPR_WR,
    output logic COND0_WE,
    output logic [3:0] COND0,
    output logic PROG_IRQ,
    output logic DBG_IRQ,
    output logic [15:0] IRQ_VECTOR,
    output logic DBG_STOP,
    output logic EXT_IRQ_ALLOW,
    output logic IRQ
);

    //==========================================================================
    // Helpers
    // Condition field zero from a result: lt, gt, eq, so
    function automatic logic [3:0] cond_of(input logic [31:0] res, input logic so);
        cond_of = {res[31], ~res[31] & (res != 32'h0), res == 32'h0, so};
    endfunction : cond_of

    //==========================================================================
    // State
    logic [2:0] dbg_control_reg;
    logic [2:0] machine_state_word;
    logic [1:0] dbg_status_reg;
    logic [3:0] evt_stat;
    logic [3:0] evt_mask;
    logic [3:0] condition_field_zero;

    // Next values, all computed in a single process
    logic [2:0] next_dbg_control_reg;
    logic [2:0] next_machine_state_word;
    logic [1:0] next_dbg_status_reg;
    logic [3:0] next_evt_stat;
    logic [3:0] next_evt_mask;
    logic [3:0] next_condition_field_zero;

    // Next values of the registered outputs
    txe_gpr_wr_s next_gpr_wr;
    logic next_cond0_we;
    logic next_prog_irq;
    logic next_dbg_irq;
    logic [15:0] next_irq_vector;
    logic next_irq;
    logic [31:0] next_rdata;

    // Decode and compare
    logic [5:0] opcd;
    logic [9:0] xo;
    logic record_bit;
    logic [4:0] trap_cond_mask;
    logic [31:0] signed_imm16_ext;
    logic [31:0] unsigned_imm16;
    logic [4:0] cmp_hit;
    logic go;
    logic is_trap;
    logic trap_hit;
    logic is_ee_reg;
    logic is_ee_imm;
    logic is_xor;
    logic is_xori;
    logic is_xoris;
    logic trap_dbg_enable;
    logic internal_dbg_mode;
    logic external_dbg_mode;
    logic dbg_exc_allow;
    logic user_mode;

    //==========================================================================
    // Instruction field decode; reserved bits are not checked
    always_comb
    begin
        opcd = EXE_REQ.insn[31:26];
        xo = EXE_REQ.insn[10:1];
        record_bit = EXE_REQ.insn[0];
        // Mask bit 0 is the leftmost bit of its field
        trap_cond_mask = {EXE_REQ.insn[21], EXE_REQ.insn[22], EXE_REQ.insn[23],
                          EXE_REQ.insn[24], EXE_REQ.insn[25]};
        signed_imm16_ext = {{16{EXE_REQ.insn[15]}}, EXE_REQ.insn[15:0]};
        unsigned_imm16 = {16'h0000, EXE_REQ.insn[15:0]};
        // Stopped core accepts nothing until the debugger releases it
        go = EXE_REQ.valid & ~dbg_status_reg[DST_STOP];
        is_trap = go & (opcd == OP_TRAP_IMM);
        is_ee_reg = go & (opcd == OP_EXT) & (xo == XO_EE_REG);
        is_ee_imm = go & (opcd == OP_EXT) & (xo == XO_EE_IMM);
        is_xor = go & (opcd == OP_EXT) & (xo == XO_XOR);
        is_xori = go & (opcd == OP_XOR_IMM);
        is_xoris = go & (opcd == OP_XOR_IMM_HI);
        // All five compares run every cycle; the mask picks the ones that count
        cmp_hit[0] = $signed(EXE_REQ.opnd_left) < $signed(signed_imm16_ext);
        cmp_hit[1] = $signed(EXE_REQ.opnd_left) > $signed(signed_imm16_ext);
        cmp_hit[2] = EXE_REQ.opnd_left == signed_imm16_ext;
        // Unsigned forms reuse the sign-extended immediate
        cmp_hit[3] = EXE_REQ.opnd_left < signed_imm16_ext;
        cmp_hit[4] = EXE_REQ.opnd_left > signed_imm16_ext;
        trap_hit = is_trap & |(cmp_hit & trap_cond_mask);
        trap_dbg_enable = dbg_control_reg[CTL_TDE];
        internal_dbg_mode = dbg_control_reg[CTL_IDM];
        external_dbg_mode = dbg_control_reg[CTL_EDM];
        dbg_exc_allow = machine_state_word[MSW_DE];
        user_mode = machine_state_word[MSW_USER];
    end

    //==========================================================================
    // Next-state: bus writes first, then instruction effects and their events, read data and interrupt level last
    always_comb
    begin
        next_dbg_control_reg = dbg_control_reg;
        next_machine_state_word = machine_state_word;
        next_dbg_status_reg = dbg_status_reg;
        next_evt_mask = evt_mask;
        next_condition_field_zero = condition_field_zero;
        next_evt_stat = evt_stat;
        next_gpr_wr = '0;
        next_cond0_we = 1'b0;
        next_prog_irq = 1'b0;
        next_dbg_irq = 1'b0;
        next_irq_vector = 16'h0000;
        next_rdata = 32'h0;

        if (REG_WR)
        begin
            unique case (REG_ADDR)
                ADR_DBG_CTRL: next_dbg_control_reg = REG_WDATA[2:0];
                ADR_MSW: next_machine_state_word = REG_WDATA[2:0];
                ADR_DBG_STAT: next_dbg_status_reg = dbg_status_reg & ~REG_WDATA[1:0];
                ADR_EVT_STAT: next_evt_stat = evt_stat & ~REG_WDATA[3:0];
                ADR_EVT_MASK: next_evt_mask = REG_WDATA[3:0];
                default: ;  // Unmapped writes are dropped
            endcase
        end

        // Trap routing; the branches are exclusive, so one vector at most
        // A trap never meets an enable fault: one instruction per cycle
        if (trap_hit)
        begin
            if (!trap_dbg_enable || (!internal_dbg_mode && !external_dbg_mode))
            begin
                next_prog_irq = 1'b1;
                next_irq_vector = VEC_PROGRAM;
                next_evt_stat[EV_PROG] = 1'b1;
            end
            else if (external_dbg_mode)
            begin
                next_dbg_status_reg[DST_STOP] = 1'b1;
                next_evt_stat[EV_STOP] = 1'b1;
                if (internal_dbg_mode && !dbg_exc_allow)
                    next_dbg_status_reg[DST_IDE] = 1'b1;
            end
            else if (dbg_exc_allow)
            begin
                next_dbg_irq = 1'b1;
                next_irq_vector = VEC_DEBUG;
                next_evt_stat[EV_DBG] = 1'b1;
            end
            else
            begin
                next_prog_irq = 1'b1;
                next_irq_vector = VEC_PROGRAM;
                next_dbg_status_reg[DST_IDE] = 1'b1;
                next_evt_stat[EV_PROG] = 1'b1;
            end
        end

        // Privileged enable writes; a fault leaves the enable alone
        if ((is_ee_reg || is_ee_imm) && user_mode)
        begin
            next_prog_irq = 1'b1;
            next_irq_vector = VEC_PROGRAM;
            next_evt_stat[EV_PRIV] = 1'b1;
        end
        else if (is_ee_reg)
            next_machine_state_word[MSW_EE] = EXE_REQ.opnd_source[15];
        else if (is_ee_imm)
            next_machine_state_word[MSW_EE] = EXE_REQ.insn[15];

        // Xor family writes the register named by the middle field
        if (is_xor || is_xori || is_xoris)
        begin
            next_gpr_wr.we = 1'b1;
            next_gpr_wr.idx = EXE_REQ.insn[20:16];
            if (is_xor)
                next_gpr_wr.data = EXE_REQ.opnd_source ^ EXE_REQ.opnd_second;
            else if (is_xori)
                next_gpr_wr.data = EXE_REQ.opnd_source ^ unsigned_imm16;
            else
                next_gpr_wr.data = EXE_REQ.opnd_source ^ {EXE_REQ.insn[15:0], 16'h0000};
        end
        if (is_xor && record_bit)
        begin
            next_cond0_we = 1'b1;
            next_condition_field_zero = cond_of(EXE_REQ.opnd_source ^ EXE_REQ.opnd_second,
                                                XER_SO);
        end

        // Read data is valid only in the cycle after the strobe
        if (REG_RD)
        begin
            unique case (REG_ADDR)
                ADR_DBG_CTRL: next_rdata = {29'h0, dbg_control_reg};
                ADR_MSW: next_rdata = {29'h0, machine_state_word};
                ADR_DBG_STAT: next_rdata = {30'h0, dbg_status_reg};
                ADR_EVT_STAT: next_rdata = {28'h0, evt_stat};
                ADR_EVT_MASK: next_rdata = {28'h0, evt_mask};
                ADR_COND0: next_rdata = {28'h0, condition_field_zero};
                default: next_rdata = 32'h0;
            endcase
        end

        // Level interrupt follows the registered status, so it is glitch free
        next_irq = |(next_evt_stat & next_evt_mask);
    end

    //==========================================================================
    // Registers
    // Reset branch loads constants only
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            dbg_control_reg <= CTL_RST;
            machine_state_word <= MSW_RST;
            dbg_status_reg <= DST_RST;
            evt_stat <= EVT_RST;
            evt_mask <= MASK_RST;
            condition_field_zero <= COND0_RST;
            // Registered outputs
            GPR_WR <= '0;
            COND0_WE <= 1'b0;
            PROG_IRQ <= 1'b0;
            DBG_IRQ <= 1'b0;
            IRQ_VECTOR <= 16'h0000;
            IRQ <= 1'b0;
            REG_RDATA <= 32'h0;
        end
        else
        begin
            dbg_control_reg <= next_dbg_control_reg;
            machine_state_word <= next_machine_state_word;
            dbg_status_reg <= next_dbg_status_reg;
            evt_stat <= next_evt_stat;
            evt_mask <= next_evt_mask;
            condition_field_zero <= next_condition_field_zero;
            // Registered outputs
            GPR_WR <= next_gpr_wr;
            COND0_WE <= next_cond0_we;
            PROG_IRQ <= next_prog_irq;
            DBG_IRQ <= next_dbg_irq;
            IRQ_VECTOR <= next_irq_vector;
            IRQ <= next_irq;
            REG_RDATA <= next_rdata;
        end
    end

    // These are aliases of state flops, not extra logic
    assign COND0 = condition_field_zero;
    assign DBG_STOP = dbg_status_reg[DST_STOP];
    assign EXT_IRQ_ALLOW = machine_state_word[MSW_EE];

    //==========================================================================
    // Assertions
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    // Trap routing cases; the internal case covers both the allowed and the masked branch
    sequence s_trap_plain;
        trap_hit && (!trap_dbg_enable || (!internal_dbg_mode && !external_dbg_mode));
    endsequence

    sequence s_trap_ext;
        trap_hit && trap_dbg_enable && external_dbg_mode;
    endsequence

    sequence s_trap_int;
        trap_hit && trap_dbg_enable && internal_dbg_mode && !external_dbg_mode;
    endsequence

    // Trap compare
    a_trap_needs_hit: assert property (
        (PROG_IRQ || DBG_IRQ) |-> $past(trap_hit || ((is_ee_reg || is_ee_imm) && user_mode)))
        else $error("interrupt without cause");

    a_trap_miss_quiet: assert property (
        (is_trap && !trap_hit) |=> !PROG_IRQ && !DBG_IRQ && !DBG_STOP)
        else $error("trap without a hit had an effect");

    a_trap_sext_eq: assert property (
        (is_trap && trap_cond_mask == 5'h04 && EXE_REQ.insn[15:0] == 16'hFFFF
         && EXE_REQ.opnd_left == 32'hFFFFFFFF) |-> trap_hit)
        else $error("immediate not sign extended");

    a_ult_compare: assert property (
        (is_trap && trap_cond_mask == 5'h08 && EXE_REQ.insn[15:0] == 16'hFFFF
         && EXE_REQ.opnd_left == 32'h1) |-> trap_hit)
        else $error("unsigned compare wrong");

    // Trap routing
    a_prog_vector: assert property (
        s_trap_plain |=> PROG_IRQ && !DBG_IRQ && IRQ_VECTOR == 16'h0700)
        else $error("plain trap not routed to program vector");

    a_ext_stop: assert property (
        s_trap_ext |=> DBG_STOP && !PROG_IRQ && !DBG_IRQ ##1 DBG_STOP)
        else $error("external debug trap did not stop");

    a_stop_drops: assert property (
        (DBG_STOP && EXE_REQ.valid) |=> !GPR_WR.we && !PROG_IRQ && !DBG_IRQ)
        else $error("request taken while stopped");

    a_ext_imprecise: assert property (
        s_trap_ext ##0 (internal_dbg_mode && !dbg_exc_allow) |=> dbg_status_reg[DST_IDE])
        else $error("imprecise flag missing on stop");

    a_int_debug_irq: assert property (
        s_trap_int ##0 dbg_exc_allow |=> DBG_IRQ && IRQ_VECTOR == 16'h2000)
        else $error("internal debug trap missed debug vector");

    a_int_masked: assert property (
        s_trap_int ##0 !dbg_exc_allow |=> PROG_IRQ && dbg_status_reg[DST_IDE])
        else $error("masked debug trap wrong");

    // Enable writes
    a_ee_reg_copy: assert property (
        (is_ee_reg && !user_mode) |=> EXT_IRQ_ALLOW == $past(EXE_REQ.opnd_source[15]))
        else $error("enable not copied from source bit");

    a_ee_imm_load: assert property (
        (is_ee_imm && !user_mode) |=> EXT_IRQ_ALLOW == $past(EXE_REQ.insn[15]))
        else $error("enable not loaded from instruction");

    a_ee_user_fault: assert property (
        ((is_ee_reg || is_ee_imm) && user_mode && !REG_WR)
        |=> PROG_IRQ && $stable(EXT_IRQ_ALLOW) && evt_stat[EV_PRIV])
        else $error("user enable write not faulted");

    // Xor family
    a_xor_result: assert property (
        is_xor |=> GPR_WR.we && GPR_WR.data == $past(EXE_REQ.opnd_source ^ EXE_REQ.opnd_second))
        else $error("xor result wrong");

    a_cond0_update: assert property (
        (is_xor && record_bit) |=> COND0_WE && COND0[1] == (GPR_WR.data == 32'h0)
                                   && COND0[3] == GPR_WR.data[31])
        else $error("condition field not updated");

    a_cond0_so: assert property (
        (is_xor && record_bit) |=> COND0[0] == $past(XER_SO))
        else $error("summary overflow not copied");

    a_xori_low: assert property (
        is_xori |=> GPR_WR.data[31:16] == $past(EXE_REQ.opnd_source[31:16]))
        else $error("xor immediate touched upper half");

    a_xoris_high: assert property (
        is_xoris |=> GPR_WR.data[15:0] == $past(EXE_REQ.opnd_source[15:0]))
        else $error("xor shifted touched lower half");

endmodule : txe_exec
`default_nettype wire

/* File: hw/txe_pkg.sv */
// Constants, register layout and carrier types for the trap/xor/enable executor
//==============================================================================
// Operation
// - Sign-extend trap immediate before comparing
// - Any enabled comparison true raises trap
// - Debug off routes trap to program vector
// - External debug trap enters debug stop
// - External stop also flags imprecise when masked; the code flags it only when internal debug mode is also set
// - Internal debug allowed gives debug interrupt
// - Internal debug masked: program plus imprecise
// - Register enable write copies source bit 15
// - Immediate enable write loads instruction bit
// - Enable writes in user mode fault
// - Nonzero reserved bits need not fault
// - Register xor writes destination register
// - Record bit updates condition field zero
// - Xor immediate zero-extends into low half
// - Xor shifted places immediate upper half
package txe_pkg;

    //==========================================================================
    // Instruction encodings
    localparam logic [5:0] OP_TRAP_IMM = 6'h03;
    localparam logic [5:0] OP_XOR_IMM = 6'h1A;
    localparam logic [5:0] OP_XOR_IMM_HI = 6'h1B;
    localparam logic [5:0] OP_EXT = 6'h1F;
    localparam logic [9:0] XO_EE_REG = 10'h083;
    localparam logic [9:0] XO_EE_IMM = 10'h0A3;
    localparam logic [9:0] XO_XOR = 10'h13C;
    localparam logic [15:0] VEC_PROGRAM = 16'h0700;
    localparam logic [15:0] VEC_DEBUG = 16'h2000;

    //==========================================================================
    // Register map (byte addresses)
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADR_DBG_CTRL = 8'h00;
    localparam logic [7:0] ADR_MSW = 8'h04;
    localparam logic [7:0] ADR_DBG_STAT = 8'h08;
    localparam logic [7:0] ADR_EVT_STAT = 8'h0C;
    localparam logic [7:0] ADR_EVT_MASK = 8'h10;
    localparam logic [7:0] ADR_COND0 = 8'h14;

    // Field positions
    localparam int CTL_TDE = 0;
    localparam int CTL_IDM = 1;
    localparam int CTL_EDM = 2;
    localparam int MSW_EE = 0;
    localparam int MSW_DE = 1;
    localparam int MSW_USER = 2;
    localparam int DST_IDE = 0;
    localparam int DST_STOP = 1;
    localparam int EV_PROG = 0;
    localparam int EV_PRIV = 1;
    localparam int EV_DBG = 2;
    localparam int EV_STOP = 3;

    // Values after reset
    localparam logic [2:0] CTL_RST = 3'h0;
    localparam logic [2:0] MSW_RST = 3'h0;
    localparam logic [1:0] DST_RST = 2'h0;
    localparam logic [3:0] EVT_RST = 4'h0;
    localparam logic [3:0] MASK_RST = 4'h0;
    localparam logic [3:0] COND0_RST = 4'h0;

    //==========================================================================
    // Carriers
    typedef struct packed {
        logic valid;
        logic [31:0] insn;
        logic [31:0] opnd_left;
        logic [31:0] opnd_source;
        logic [31:0] opnd_second;
    } txe_exec_req_s;

    typedef struct packed {
        logic we;
        logic [4:0] idx;
        logic [31:0] data;
    } txe_gpr_wr_s;

endpackage : txe_pkg

/* File: dv/tb_trap_xor_eeflag_exec.sv */
// Self-checking testbench for the trap, xor and external-enable executor
`timescale 1ns/1ps
`default_nettype none
module tb_trap_xor_eeflag_exec;
    import txe_pkg::*;

    //==========================================================================
    // Signals and design instance
    logic clk;
    logic rst;
    txe_exec_req_s req;
    logic xer_so;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    txe_gpr_wr_s gpr_wr;
    logic cond0_we;
    logic [3:0] cond0;
    logic prog_irq;
    logic dbg_irq;
    logic [15:0] irq_vector;
    logic dbg_stop;
    logic ext_irq_allow;
    logic irq;
    int err_total;
    int total_checks;

    txe_exec dut_u (.CLK(clk), .RST(rst), .EXE_REQ(req), .XER_SO(xer_so),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_RDATA(reg_rdata), .GPR_WR(gpr_wr), .COND0_WE(cond0_we), .COND0(cond0),
        .PROG_IRQ(prog_irq), .DBG_IRQ(dbg_irq), .IRQ_VECTOR(irq_vector),
        .DBG_STOP(dbg_stop), .EXT_IRQ_ALLOW(ext_irq_allow), .IRQ(irq));

    // 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    //==========================================================================
    // Compare tasks
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk_word

    task automatic chk_flag(input logic got, input logic exp, input string what);
        chk_word({31'h0, got}, {31'h0, exp}, what);
    endtask : chk_flag

    // Pulses and stop level seen in the cycle after an instruction
    task automatic chk_resp(input logic p, input logic d, input logic [15:0] v, input logic st);
        chk_flag(prog_irq, p, "program pulse");
        chk_flag(dbg_irq, d, "debug pulse");
        chk_word({16'h0000, irq_vector}, {16'h0000, v}, "vector");
        chk_flag(dbg_stop, st, "stop level");
    endtask : chk_resp

    // Interrupt output is registered from the status, so allow it to settle
    task automatic chk_irq(input logic e);
        repeat (2) @(posedge clk);
        #1;
        chk_flag(irq, e, "irq level");
    endtask : chk_irq

    //==========================================================================
    // Bus and instruction drivers
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask : reg_write

    // Read data stand only in the cycle after the strobe
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk_word(reg_rdata, exp, what);
    endtask : chk_reg

    task automatic exec(input logic [31:0] i, input logic [31:0] l, input logic [31:0] s,
        input logic [31:0] b);
        @(posedge clk);
        req <= '{1'b1, i, l, s, b};
        @(posedge clk);
        req.valid <= 1'b0;
        #1;
    endtask : exec

    function automatic logic [31:0] enc_x(input logic [4:0] s, input logic [4:0] a,
        input logic [9:0] xo, input logic rc);
        return {OP_EXT, s, a, 5'h0A, xo, rc};
    endfunction : enc_x

    // Expected trap outcome worked out from the mask bits
    function automatic logic trap_hit(input logic [4:0] to, input logic [31:0] a,
        input logic [15:0] si);
        logic [31:0] b;
        b = {{16{si[15]}}, si};
        return (to[4] && $signed(a) < $signed(b)) || (to[3] && $signed(a) > $signed(b))
            || (to[2] && a == b) || (to[1] && a < b) || (to[0] && a > b);
    endfunction : trap_hit

    //==========================================================================
    // Scenarios
    task automatic t_reset();
        for (int k = 0; k <= 24; k += 4)
            chk_reg(8'(k), 32'h0000_0000, "reset value");
        // Condition field is read-only, so a write must not land
        reg_write(ADR_COND0, 32'h0000_000F);
        chk_reg(ADR_COND0, 32'h0000_0000, "read-only cond");
        chk_resp(1'b0, 1'b0, 16'h0000, 1'b0);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_trap_cmp();
        logic [31:0] lv [3] = '{32'hFFFF_FFFE, 32'h0000_0001, 32'hFFFF_FFFF};
        logic [15:0] iv [3] = '{16'h0001, 16'hFFFF, 16'hFFFF};
        logic [4:0] to;
        logic h;
        for (int c = 0; c < 3; c++)
            for (int k = 0; k < 6; k++)
            begin
                to = (k < 5) ? (5'h10 >> k) : 5'h00;
                h = trap_hit(to, lv[c], iv[c]);
                exec({OP_TRAP_IMM, to, 5'h03, iv[c]}, lv[c], 32'hA5A5_A5A5, 32'h5A5A_5A5A);
                chk_resp(h, 1'b0, h ? VEC_PROGRAM : 16'h0000, 1'b0);
            end
        chk_reg(ADR_EVT_STAT, 32'h0000_0001, "program event");
        reg_write(ADR_EVT_STAT, 32'h0000_000F);
        chk_reg(ADR_EVT_STAT, 32'h0000_0000, "event cleared");
        $display("t_trap_cmp done");
    endtask : t_trap_cmp

    task automatic dbg_case(input logic [2:0] ctl, input logic de, input logic p,
        input logic d, input logic st, input logic imprecise_dbg_flag);
        reg_write(ADR_DBG_CTRL, {29'h0, ctl});
        reg_write(ADR_MSW, {30'h0, de, 1'b0});
        exec({OP_TRAP_IMM, 5'h04, 5'h01, 16'h0005}, 32'h5, 32'h0, 32'h0);
        chk_resp(p, d, p ? VEC_PROGRAM : (d ? VEC_DEBUG : 16'h0000), st);
        chk_reg(ADR_EVT_STAT, {28'h0, st, d, 1'b0, p}, "event bits");
        // While stopped the request is dropped and nothing is written back
        exec(enc_x(5'h01, 5'h02, XO_XOR, 1'b0), 32'h0, 32'h1, 32'h2);
        chk_flag(gpr_wr.we, !st, "write while stopped");
        chk_reg(ADR_DBG_STAT, {30'h0, st, imprecise_dbg_flag}, "debug status");
        reg_write(ADR_DBG_STAT, 32'h0000_0003);
        chk_flag(dbg_stop, 1'b0, "stop release");
        reg_write(ADR_EVT_STAT, 32'h0000_000F);
    endtask : dbg_case

    task automatic t_debug();
        dbg_case(3'b000, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        dbg_case(3'b001, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        dbg_case(3'b110, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        dbg_case(3'b011, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        dbg_case(3'b011, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
        dbg_case(3'b101, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        dbg_case(3'b111, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
        dbg_case(3'b111, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        reg_write(ADR_DBG_CTRL, 32'h0000_0000);
        $display("t_debug done");
    endtask : t_debug

    task automatic t_irq();
        reg_write(ADR_EVT_MASK, 32'h0000_0001);
        chk_reg(ADR_EVT_MASK, 32'h0000_0001, "mask readback");
        exec({OP_TRAP_IMM, 5'h04, 5'h01, 16'h0000}, 32'h0, 32'h0, 32'h0);
        chk_irq(1'b1);
        reg_write(ADR_EVT_MASK, 32'h0000_0000);
        chk_irq(1'b0);
        reg_write(ADR_EVT_MASK, 32'h0000_0001);
        chk_irq(1'b1);
        reg_write(ADR_EVT_STAT, 32'h0000_0001);
        chk_irq(1'b0);
        $display("t_irq done");
    endtask : t_irq

    task automatic t_ee();
        logic [31:0] ei1 = {OP_EXT, 10'h000, 1'b1, 4'h0, XO_EE_IMM, 1'b0};
        reg_write(ADR_MSW, 32'h0000_0000);
        exec(enc_x(5'h07, 5'h00, XO_EE_REG, 1'b0), 32'h0, 32'h0000_8000, 32'h0);
        // The encoder leaves nonzero reserved bits in the third register field
        chk_flag(ext_irq_allow, 1'b1, "ee from source");
        exec(enc_x(5'h07, 5'h00, XO_EE_REG, 1'b0), 32'h0, 32'hFFFF_7FFF, 32'h0);
        chk_flag(ext_irq_allow, 1'b0, "ee from source");
        exec(ei1, 32'h0, 32'h0, 32'h0);
        chk_flag(ext_irq_allow, 1'b1, "ee immediate");
        chk_reg(ADR_MSW, 32'h0000_0001, "msw readback");
        exec(ei1 ^ 32'h0000_8000, 32'h0, 32'h0, 32'h0);
        chk_flag(ext_irq_allow, 1'b0, "ee immediate");
        // User mode refuses both forms and leaves the enable alone
        reg_write(ADR_MSW, 32'h0000_0004);
        exec(ei1, 32'h0, 32'h0, 32'h0);
        chk_resp(1'b1, 1'b0, VEC_PROGRAM, 1'b0);
        exec(enc_x(5'h07, 5'h00, XO_EE_REG, 1'b0), 32'h0, 32'hFFFF_FFFF, 32'h0);
        chk_flag(ext_irq_allow, 1'b0, "user ee kept");
        chk_reg(ADR_EVT_STAT, 32'h0000_0002, "privilege event");
        reg_write(ADR_EVT_STAT, 32'h0000_000F);
        reg_write(ADR_MSW, 32'h0000_0000);
        $display("t_ee done");
    endtask : t_ee

    task automatic t_xor();
        logic [31:0] sv [4] = '{32'h1234_5678, 32'h8000_0000, 32'h0F0F_0F0F, 32'hDEAD_BEEF};
        logic [31:0] bv [4] = '{32'h1234_5678, 32'h0000_0001, 32'h00FF_00FF, 32'h0000_FFFF};
        logic [3:0] ce;
        logic [31:0] r;
        for (int c = 0; c < 4; c++)
        begin
            r = sv[c] ^ bv[c];
            @(posedge clk);
            xer_so <= c[0];
            exec(enc_x(5'h05, 5'h1D, XO_XOR, c != 3), 32'h5555_0000, sv[c], bv[c]);
            chk_word(gpr_wr.data, r, "xor write");
            chk_word({27'h0, gpr_wr.idx}, 32'h0000_001D, "xor dest");
            chk_flag(cond0_we, c != 3, "cond write");
            if (c != 3)
                ce = {$signed(r) < 0, $signed(r) > 0, r == 0, c[0]};
            chk_reg(ADR_COND0, {28'h0, ce}, "cond field");
            chk_word({28'h0, cond0}, {28'h0, ce}, "cond port");
        end
        exec({OP_XOR_IMM, 5'h02, 5'h11, 16'h8001}, 32'h0, 32'h1234_5678, 32'hFFFF_FFFF);
        chk_word(gpr_wr.data, 32'h1234_D679, "xor low imm");
        exec({OP_XOR_IMM_HI, 5'h02, 5'h11, 16'h8001}, 32'h0, 32'h1234_5678, 32'hFFFF_FFFF);
        chk_word(gpr_wr.data, 32'h9235_5678, "xor hi");
        chk_word({27'h0, gpr_wr.idx}, 32'h0000_0011, "xor hi dest");
        $display("t_xor done");
    endtask : t_xor

    //==========================================================================
    // Verdict and run control
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test

    // Whole run needs well under two thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        stop_test();
    end

    initial
    begin
        err_total = 0;
        total_checks = 0;
        rst = 1'b1;
        req = '0;
        xer_so = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_trap_cmp();
        t_debug();
        t_irq();
        t_ee();
        t_xor();
        stop_test();
    end

endmodule : tb_trap_xor_eeflag_exec
`default_nettype wire
